// File: sim/frc_host_model.sv
// Host controller model: makes select, link clock and data lines, one frame at a time
module frc_host_model #(
  parameter int GAP_NS = 2000
) (
  output logic           sclk,
  output logic           cs_n,
  output logic [3:0]     dq_drv,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] last;
  logic [3:0] seen;
  // An undriven line toggles, so a stale value can never pass as data
  assign seen = (dev_oe & dev_out) | (~dev_oe & ~last);
  always @(negedge sclk) last <= seen;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq_drv = 4'h0;
    last = 4'h0;
  end
  task automatic tick();
    repeat (2) begin
      #40 sclk = 1'b1;
      #40 sclk = 1'b0;
    end
  endtask
  // Never enters execute-in-place, so reset pairs start from plain commands
  task automatic frame(input int w, input logic [7:0] tx[$], input int nrd,
                       output logic [7:0] rx[$]);
    logic [3:0] m;
    logic [7:0] v;
    m = 4'((1 << w) - 1);
    rx = {};
    cs_n = 1'b0;
    #40;
    foreach (tx[i]) begin
      for (int b = 8 - w; b >= 0; b -= w) begin
        dq_drv = 4'(tx[i] >> b) & m;
        #40 sclk = 1'b1;
        #40 sclk = 1'b0;
      end
    end
    for (int k = 0; k < nrd; k++) begin
      v = 8'h00;
      for (int b = 0; b < 8; b += w) begin
        #40 sclk = 1'b1;
        v = (v << w) | ((w == 1) ? 8'(seen[1]) : 8'(seen & m));
        #40 sclk = 1'b0;
        dq_drv = ~dq_drv;
      end
      rx.push_back(v);
    end
    #40 cs_n = 1'b1;
    #GAP_NS;
  endtask
endmodule // frc_host_model

// File: sim/frc_props.sv
// Assertions on reset pulse, abort, lock state and line drive of the command block
module frc_props (
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic                   cs_n,
  input wire logic [3:0]             serial_data_lines_oe,
  input wire frc_pkg::frc_proto_type proto,
  input wire logic                   nv_addr4,
  input wire logic [7:0]             nv_lock_default,
  input wire logic                   core_busy,
  input wire logic                   core_suspended,
  input wire logic                   addr4,
  input wire logic                   reset_pulse,
  input wire logic                   abort_req,
  input wire logic [7:0]             lock_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  import frc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_pulse_one; reset_pulse |=> !reset_pulse; endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");
  property p_pulse_desel; reset_pulse |-> cs_n && $past(cs_n, 2); endproperty
  a_pulse_desel: assert property (p_pulse_desel) else $error("reset while selected");
  property p_abort_only; abort_req |-> reset_pulse; endproperty
  a_abort_only: assert property (p_abort_only) else $error("abort without reset");
  property p_abort_cause;
    reset_pulse && $past(core_busy || core_suspended) |-> abort_req;
  endproperty
  a_abort_cause: assert property (p_abort_cause) else $error("abort missing");
  property p_lock_rst; reset_pulse |-> ##[0:3] (lock_bits == nv_lock_default); endproperty
  a_lock_rst: assert property (p_lock_rst) else $error("locks not restored");
  property p_addr4_rst; reset_pulse |-> ##[0:3] (addr4 == nv_addr4); endproperty
  a_addr4_rst: assert property (p_addr4_rst) else $error("address mode not restored");
  property p_lock_quiet; $changed(lock_bits) |-> cs_n; endproperty
  a_lock_quiet: assert property (p_lock_quiet) else $error("locks changed mid frame");
  property p_oe_idle; cs_n && $past(cs_n, 2) |-> serial_data_lines_oe == 4'h0; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("drive while deselected");
  property p_ext_lines;
    proto == FRC_PROTO_EXT |-> serial_data_lines_oe[3:2] == 2'h0 && !serial_data_lines_oe[0];
  endproperty
  a_ext_lines: assert property (p_ext_lines) else $error("extra line driven");
  property p_dual_lines; proto == FRC_PROTO_DUAL |-> serial_data_lines_oe[3:2] == 2'h0; endproperty
  a_dual_lines: assert property (p_dual_lines) else $error("upper lines driven");
  c_pulse: cover property (reset_pulse);
  c_abort: cover property (abort_req);
  c_drive: cover property ($rose(serial_data_lines_oe[1]));
endmodule // frc_props

// File: sim/frc_top_tb.sv
// Self-checking bench for the flash reset and identification command block
module frc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import frc_pkg::*;
  logic          clk, rstn, sclk, cs_n, nv_addr4, core_busy, core_suspended, cfg_write_busy;
  logic          addr4, reset_pulse, abort_req;
  logic [3:0]    din, dout, doe;
  logic [7:0]    nvl, lock_bits, d;
  logic [7:0]    m_lock;
  logic [7:0]    rx[$], q[$];
  logic [4:0]    cfgd;
  frc_proto_type proto;
  int            n_mismatch, n_compared, n_pulse, n_abort, n_drive, d0;
  logic [7:0]    id_exp[4] = '{ID_BYTE0, ID_BYTE1, ID_BYTE2, 8'h00};
  logic [7:0]    id_op[3] = '{OP_RD_ID_A, OP_RD_ID_B, OP_RD_ID_MIO};
  frc_proto_type id_pr[3] = '{FRC_PROTO_EXT, FRC_PROTO_EXT, FRC_PROTO_QUAD};
  frc_top dut_u (.clk(clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n),
    .serial_data_lines_in(din), .serial_data_lines_out(dout), .serial_data_lines_oe(doe),
    .proto(proto), .nv_addr4(nv_addr4), .cfg_dummy(cfgd), .nv_lock_default(nvl),
    .core_busy(core_busy), .core_suspended(core_suspended), .cfg_write_busy(cfg_write_busy),
    .addr4(addr4), .reset_pulse(reset_pulse), .abort_req(abort_req), .lock_bits(lock_bits));
  frc_host_model host_u (.sclk(sclk), .cs_n(cs_n), .dq_drv(din), .dev_out(dout), .dev_oe(doe));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (reset_pulse === 1'b1) n_pulse <= n_pulse + 1;
  always @(posedge clk) if (abort_req === 1'b1) n_abort <= n_abort + 1;
  always @(posedge sclk) if (doe[1] === 1'b1) n_drive <= n_drive + 1;
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] tx[$], input int nrd = 0);
    host_u.frame(1 << int'(proto), tx, nrd, rx);
  endtask
  task automatic set_proto(input frc_proto_type p);
    @(posedge clk);
    #1 proto = p;
  endtask
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_mismatch++;
    final_report();
  end
  initial begin
    void'($urandom(32'h602e4f8f));
    nvl = 8'($urandom);
    cfgd = 5'(2 + 2 * ($urandom % 8));
    {rstn, nv_addr4, core_busy, core_suspended, cfg_write_busy} = 5'h00;
    proto = FRC_PROTO_EXT;
    host_u.tick();
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    host_u.tick();
    for (int p = 0; p < 3; p++) begin
      set_proto(frc_proto_type'(p));
      send({OP_RST_EN});
      send({OP_RST_MEM});
      check("reset count", 8'(n_pulse), 8'(p + 1));
      check("locks", lock_bits, nvl);
    end
    m_lock = nvl;
    set_proto(FRC_PROTO_EXT);
    send({OP_RD_FLAG}, 2);
    check("flag ready", rx[0] & 8'h80, FLAG_READY);
    d0 = n_drive;
    send({8'h3a, OP_RD_ID_B}, 2);
    check("drive after unknown", 8'(n_drive - d0), 8'h00);
    send({OP_RD_ID_B}, 1);
    check("partial id", rx[0], ID_BYTE0);
    d0 = n_drive;
    send({OP_RD_GPRR, 8'h00}, GPRR_LEN + 2);
    check("gprr drive", 8'(n_drive - d0), 8'(8 * (GPRR_LEN + 2)));
    check("gprr tail", rx[GPRR_LEN] | rx[GPRR_LEN + 1], 8'h00);
    for (int p = 0; p < 3; p++) begin
      set_proto(id_pr[p]);
      send({id_op[p]}, 4);
      foreach (rx[i]) check("id byte", rx[i], id_exp[i]);
    end
    set_proto(FRC_PROTO_EXT);
    d = nvl ^ 8'($urandom | 1);
    send({OP_WR_LOCK4, 8'h00, 8'h00, 8'h00, 8'h00, d});
    check("lock no wren", lock_bits, m_lock);
    send({OP_WREN});
    send({OP_WR_LOCK4, 8'h00, 8'h00, 8'h00, 8'h00, d});
    m_lock = d;
    check("lock write", lock_bits, m_lock);
    send({OP_RD_LOCK4, 8'h00, 8'h00, 8'h00, 8'h00}, 2);
    check("lock read 4b", rx[0], m_lock);
    send({OP_ENTER_4B});
    check("addr4", 8'(addr4), 8'h01);
    send({OP_RD_LOCK, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    check("lock read mode", rx[0], m_lock);
    d0 = n_drive;
    send({OP_RD_DISC, 8'h00, 8'h00, 8'h00, 8'h00}, 1);
    check("disc drive", 8'(n_drive - d0), 8'h08);
    q = {OP_FAST_READ, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (cfgd / 2) q.push_back(8'h00);
    set_proto(FRC_PROTO_QUAD);
    d0 = n_drive;
    send(q, 2);
    check("fast read drive", 8'(n_drive - d0), 8'h04);
    set_proto(FRC_PROTO_EXT);
    @(posedge clk);
    #1 core_busy = 1'b1;
    d0 = n_drive;
    send({OP_RD_ID_B}, 3);
    check("id while busy", 8'(n_drive - d0), 8'h00);
    @(posedge clk);
    #1 {core_busy, core_suspended} = 2'b01;
    send({OP_RST_EN});
    send({OP_RST_MEM});
    check("abort", 8'(n_abort), 8'h01);
    check("locks", lock_bits, nvl);
    check("addr4 restored", 8'(addr4), 8'(nv_addr4));
    @(posedge clk);
    #1 core_suspended = 1'b0;
    send({OP_RST_MEM});
    check("lone reset", 8'(n_pulse), 8'h04);
    send({OP_ENTER_4B});
    send({OP_EXIT_4B});
    check("addr4 exit", 8'(addr4), 8'h00);
    @(posedge clk);
    #1 cfg_write_busy = 1'b1;
    send({OP_RST_EN});
    @(posedge clk);
    #1 cfg_write_busy = 1'b0;
    send({OP_RST_MEM});
    check("reset in cfg write", 8'(n_pulse), 8'h04);
    final_report();
  end
endmodule // frc_top_tb
bind frc_top frc_props chk_u (.clk(clk), .rstn(rstn), .cs_n(cs_n),
  .serial_data_lines_oe(serial_data_lines_oe), .proto(proto), .nv_addr4(nv_addr4),
  .nv_lock_default(nv_lock_default), .core_busy(core_busy), .core_suspended(core_suspended),
  .addr4(addr4), .reset_pulse(reset_pulse), .abort_req(abort_req), .lock_bits(lock_bits));

// File: verilog/frc_pkg.sv
// Constants and types shared by the flash reset and identification command block
package frc_pkg;
  localparam logic [7:0] OP_RD_LOCK4   = 8'he0;
  localparam logic [7:0] OP_WR_LOCK4   = 8'he1;
  localparam logic [7:0] OP_RD_LOCK    = 8'he8;
  localparam logic [7:0] OP_WR_LOCK    = 8'he5;
  localparam logic [7:0] OP_RD_DISC    = 8'h5a;
  localparam logic [7:0] OP_RD_GPRR    = 8'h96;
  localparam logic [7:0] OP_FAST_READ  = 8'h0b;
  localparam logic [7:0] OP_WREN       = 8'h06;
  localparam logic [7:0] OP_RST_EN     = 8'h66;
  localparam logic [7:0] OP_RST_MEM    = 8'h99;
  localparam logic [7:0] OP_RD_ID_A    = 8'h9e;
  localparam logic [7:0] OP_RD_ID_B    = 8'h9f;
  localparam logic [7:0] OP_RD_ID_MIO  = 8'haf;
  localparam logic [7:0] OP_RD_FLAG    = 8'h70;
  localparam logic [7:0] OP_ENTER_4B   = 8'hb7;
  localparam logic [7:0] OP_EXIT_4B    = 8'he9;
  // Identification bytes: arbitrary neutral values
  localparam logic [7:0] ID_BYTE0      = 8'h5e;
  localparam logic [7:0] ID_BYTE1      = 8'ha5;
  localparam logic [7:0] ID_BYTE2      = 8'h3c;
  localparam int         ID_LEN        = 3;
  localparam int         GPRR_LEN      = 64;
  localparam logic [4:0] GPRR_DUMMY    = 5'h08;
  localparam logic [4:0] DISC_DUMMY    = 5'h08;
  localparam logic [7:0] LOCK_RESET    = 8'h00;
  localparam logic [7:0] FLAG_READY    = 8'h80;
  // Power-on reset after reset-memory, given in ns and rounded up to system-clock cycles
  localparam int         POR_TIME_NS   = 1000;
  localparam int         CLK_PERIOD_NS = 100;
  localparam logic [7:0] POR_CYCLES    = 8'((POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [1:0] {
    FRC_PROTO_EXT  = 2'h0,
    FRC_PROTO_DUAL = 2'h1,
    FRC_PROTO_QUAD = 2'h2
  } frc_proto_type;
  typedef enum logic [2:0] {
    FRC_ST_OPCODE = 3'h0,
    FRC_ST_ADDR   = 3'h1,
    FRC_ST_DUMMY  = 3'h3,
    FRC_ST_DATA   = 3'h2,
    FRC_ST_WDATA  = 3'h6,
    FRC_ST_IGNORE = 3'h7
  } frc_state_type;
endpackage

// File: verilog/frc_top.sv
// Command decoder for reset pair, identification and lock commands of a serial flash
module frc_top (
  // System clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // Serial link, clocked by the host
  input  wire logic               sclk,
  input  wire logic               cs_n,
  input  wire logic [3:0]         serial_data_lines_in,
  output logic      [3:0]         serial_data_lines_out,
  output logic      [3:0]         serial_data_lines_oe,
  // Configuration
  input  wire frc_pkg::frc_proto_type proto,
  input  wire logic               nv_addr4,
  input  wire logic [4:0]         cfg_dummy,
  input  wire logic [7:0]         nv_lock_default,
  // Memory core status
  input  wire logic               core_busy,
  input  wire logic               core_suspended,
  input  wire logic               cfg_write_busy,
  // Status and events towards the core
  output logic                    addr4,
  output logic                    reset_pulse,
  output logic                    abort_req,
  output logic [7:0]              lock_bits
);
  import frc_pkg::*;

  // Reset release
  logic rst_s1, rst_n_sys;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1    <= 1'b0;
      rst_n_sys <= 1'b0;
    end else begin
      rst_s1    <= 1'b1;
      rst_n_sys <= rst_s1;
    end
  end

  // Link domain reset: async assert, sync release on sclk
  logic lr_s1, rst_n_link;
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      lr_s1      <= 1'b0;
      rst_n_link <= 1'b0;
    end else begin
      lr_s1      <= 1'b1;
      rst_n_link <= lr_s1;
    end
  end

  function automatic logic [2:0] lines_of(input frc_proto_type p);
    unique case (p)
      FRC_PROTO_EXT:  lines_of = 3'h1;
      FRC_PROTO_DUAL: lines_of = 3'h2;
      FRC_PROTO_QUAD: lines_of = 3'h4;
      default:        lines_of = 3'h1;
    endcase
  endfunction

  // Busy levels from the system domain, synchronised into the link domain
  logic busy_s1, busy_l, cfgw_s1, cfgw_l;
  always_ff @(posedge sclk or negedge rst_n_link) begin
    if (!rst_n_link) begin
      busy_s1 <= 1'b0;
      busy_l  <= 1'b0;
      cfgw_s1 <= 1'b0;
      cfgw_l  <= 1'b0;
    end else begin
      busy_s1 <= core_busy | core_suspended;
      busy_l  <= busy_s1;
      cfgw_s1 <= cfg_write_busy;
      cfgw_l  <= cfgw_s1;
    end
  end

  // Link-side frame logic; chip select acts as frame reset
  frc_state_type state;
  logic [7:0]    shreg;
  logic [3:0]    bitcnt;
  logic [7:0]    opcode;
  logic [2:0]    addr_left;
  logic [4:0]    dummy_left;
  logic [6:0]    byte_idx;
  logic [7:0]    obyte;
  logic [2:0]    nlines;
  logic          wren_l, rst_armed, rst_req_tog, lock_wr_tog, porting;
  logic          a4_tog, a4_val;
  logic [7:0]    lock_wr_val;
  logic [7:0]    next_shreg;
  logic [3:0]    next_bitcnt;
  logic          byte_done;

  assign nlines = lines_of(proto);

  always_comb begin
    next_shreg  = shreg;
    next_bitcnt = bitcnt + 4'(nlines);
    unique case (nlines)
      3'h4:    next_shreg = {shreg[3:0], serial_data_lines_in};
      3'h2:    next_shreg = {shreg[5:0], serial_data_lines_in[1:0]};
      default: next_shreg = {shreg[6:0], serial_data_lines_in[0]};
    endcase
  end
  assign byte_done = (next_bitcnt == 4'h8);

  function automatic logic [7:0] gprr_byte(input logic [6:0] idx);
    gprr_byte = (idx < 7'(GPRR_LEN)) ? {1'b0, idx} : 8'h00;
  endfunction

  function automatic logic [7:0] out_byte(input logic [7:0] op, input logic [6:0] idx,
                                          input logic [7:0] lk, input logic por);
    unique case (op)
      OP_RD_ID_A, OP_RD_ID_B, OP_RD_ID_MIO:
        out_byte = (idx == 7'h0) ? ID_BYTE0 : (idx == 7'h1) ? ID_BYTE1 :
                   (idx == 7'h2) ? ID_BYTE2 : 8'h00;
      OP_RD_GPRR:            out_byte = gprr_byte(idx);
      OP_RD_FLAG:            out_byte = por ? 8'h00 : FLAG_READY;
      OP_RD_LOCK4, OP_RD_LOCK: out_byte = lk;
      default:               out_byte = 8'h00;
    endcase
  endfunction

  // Lock value seen by the link: settled copy from system domain
  // These words only change between frames while sclk idles, so two flops suffice
  logic [7:0] lock_l1, lock_l;
  logic       addr4_l1, addr4_l, por_l1, por_l;
  always_ff @(posedge sclk or negedge rst_n_link) begin
    if (!rst_n_link) begin
      lock_l1 <= LOCK_RESET; lock_l <= LOCK_RESET;
      addr4_l1 <= 1'b0; addr4_l <= 1'b0; por_l1 <= 1'b0; por_l <= 1'b0;
    end else begin
      lock_l1 <= lock_bits; lock_l <= lock_l1;
      addr4_l1 <= addr4; addr4_l <= addr4_l1;
      por_l1 <= porting; por_l <= por_l1;
    end
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      state      <= FRC_ST_OPCODE;
      shreg      <= 8'h00;
      bitcnt     <= 4'h0;
      opcode     <= 8'h00;
      addr_left  <= 3'h0;
      dummy_left <= 5'h00;
      byte_idx   <= 7'h00;
    end else begin
      shreg  <= next_shreg;
      bitcnt <= byte_done ? 4'h0 : next_bitcnt;
      unique case (state)
        FRC_ST_OPCODE: if (byte_done) begin
          opcode <= next_shreg;
          unique case (next_shreg)
            OP_RD_LOCK4, OP_WR_LOCK4: begin
              state <= FRC_ST_ADDR; addr_left <= 3'h4;
            end
            OP_RD_LOCK, OP_WR_LOCK, OP_FAST_READ: begin
              state <= FRC_ST_ADDR; addr_left <= addr4_l ? 3'h4 : 3'h3;
            end
            OP_RD_DISC: begin
              state <= FRC_ST_ADDR; addr_left <= 3'h3;
            end
            OP_RD_GPRR: begin
              state <= FRC_ST_DUMMY; dummy_left <= GPRR_DUMMY;
            end
            OP_RD_ID_A, OP_RD_ID_B, OP_RD_ID_MIO:
              state <= busy_l ? FRC_ST_IGNORE : FRC_ST_DATA;
            OP_RD_FLAG: state <= FRC_ST_DATA;
            default:    state <= FRC_ST_IGNORE;
          endcase
        end
        FRC_ST_ADDR: if (byte_done) begin
          addr_left <= addr_left - 3'h1;
          if (addr_left == 3'h1) begin
            if (opcode == OP_WR_LOCK4 || opcode == OP_WR_LOCK) state <= FRC_ST_WDATA;
            else if (opcode == OP_FAST_READ) begin
              state <= FRC_ST_DUMMY; dummy_left <= cfg_dummy;
            end else if (opcode == OP_RD_DISC) begin
              state <= FRC_ST_DUMMY; dummy_left <= DISC_DUMMY;
            end else state <= FRC_ST_DATA; // zero dummy
          end
        end
        FRC_ST_DUMMY: begin
          bitcnt     <= 4'h0;
          dummy_left <= dummy_left - 5'h01;
          if (dummy_left <= 5'h01) state <= FRC_ST_DATA;
        end
        FRC_ST_DATA: if (byte_done) byte_idx <= byte_idx + ((byte_idx == 7'h7f) ? 7'h0 : 7'h1);
        FRC_ST_WDATA: if (byte_done) state <= FRC_ST_IGNORE; // one byte only
        FRC_ST_IGNORE: ;
        default: state <= FRC_ST_IGNORE;
      endcase
    end
  end

  // Output byte chosen combinationally; the falling-edge shifter only picks its bits
  assign obyte = out_byte(opcode, byte_idx, lock_l, por_l);

  // Output shifter on falling edge
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      serial_data_lines_out <= 4'h0;
      serial_data_lines_oe  <= 4'h0;
    end else if (state == FRC_ST_DATA) begin
      unique case (nlines)
        3'h4: begin
          serial_data_lines_out <= bitcnt[2] ? obyte[3:0] : obyte[7:4];
          serial_data_lines_oe  <= 4'hf;
        end
        3'h2: begin
          serial_data_lines_out <= {2'h0, obyte[3'(7 - bitcnt) -: 2]};
          serial_data_lines_oe  <= 4'h3;
        end
        default: begin
          serial_data_lines_out <= {2'h0, obyte[3'(7 - bitcnt)], 1'b0};
          serial_data_lines_oe  <= 4'h2;
        end
      endcase
    end else begin
      serial_data_lines_out <= 4'h0;
      serial_data_lines_oe  <= 4'h0;
    end
  end

  // Command completion at frame end: latched at last byte, acted on at deselect
  always_ff @(posedge cs_n or negedge rst_n_link) begin
    if (!rst_n_link) begin
      wren_l      <= 1'b0;
      rst_armed   <= 1'b0;
      rst_req_tog <= 1'b0;
      lock_wr_tog <= 1'b0;
      lock_wr_val <= LOCK_RESET;
      a4_tog      <= 1'b0;
      a4_val      <= 1'b0;
    end else begin
      rst_armed <= 1'b0;
      if (state == FRC_ST_IGNORE && (opcode == OP_WR_LOCK4 || opcode == OP_WR_LOCK)) begin
        if (wren_l) begin
          lock_wr_tog <= ~lock_wr_tog;
          lock_wr_val <= shreg;
        end
        wren_l <= 1'b0;
      end else if (state == FRC_ST_IGNORE && opcode == OP_WREN) wren_l <= 1'b1;
      // Address mode commands need no write enable
      if (state == FRC_ST_IGNORE && (opcode == OP_ENTER_4B || opcode == OP_EXIT_4B)) begin
        a4_tog <= ~a4_tog;
        a4_val <= (opcode == OP_ENTER_4B);
      end
      if (state == FRC_ST_IGNORE && opcode == OP_RST_EN && !cfgw_l)
        rst_armed <= 1'b1;
      if (state == FRC_ST_IGNORE && opcode == OP_RST_MEM && rst_armed) begin
        rst_req_tog <= ~rst_req_tog;
        wren_l      <= 1'b0;
      end
    end
  end

  // System domain: event toggles crossed by two flip-flops plus edge compare
  logic [2:0] rst_sync, lk_sync, a4_sync;
  logic [7:0] lk_val_s;
  logic [7:0] por_cnt;
  logic       a4_val_s;
  always_ff @(posedge clk or negedge rst_n_sys) begin
    if (!rst_n_sys) begin
      rst_sync <= 3'h0;
      lk_sync  <= 3'h0;
      a4_sync  <= 3'h0;
    end else begin
      rst_sync <= {rst_sync[1:0], rst_req_tog};
      lk_sync  <= {lk_sync[1:0], lock_wr_tog};
      a4_sync  <= {a4_sync[1:0], a4_tog};
    end
  end

  always_ff @(posedge clk or negedge rst_n_sys) begin
    if (!rst_n_sys) begin
      reset_pulse <= 1'b0;
      abort_req   <= 1'b0;
      por_cnt     <= 8'h00;
      porting     <= 1'b0;
    end else begin
      reset_pulse <= rst_sync[2] ^ rst_sync[1];
      abort_req   <= (rst_sync[2] ^ rst_sync[1]) & (core_busy | core_suspended);
      if (rst_sync[2] ^ rst_sync[1]) begin
        por_cnt <= POR_CYCLES;
        porting <= 1'b1;
      end else if (por_cnt != 8'h00) por_cnt <= por_cnt - 8'h01;
      else porting <= 1'b0; // flag bit 7 returns
    end
  end

  // Volatile state restored on software reset
  always_ff @(posedge clk or negedge rst_n_sys) begin
    if (!rst_n_sys) begin
      lock_bits  <= LOCK_RESET;
      addr4      <= 1'b0;
      lk_val_s   <= LOCK_RESET;
      a4_val_s   <= 1'b0;
    end else begin
      lk_val_s <= lock_wr_val;
      a4_val_s <= a4_val;
      // A software reset wins over a mode or lock change landing in the same cycle
      if (rst_sync[2] ^ rst_sync[1]) begin
        lock_bits <= nv_lock_default;
        addr4     <= nv_addr4;
      end else begin
        if (lk_sync[2] ^ lk_sync[1]) lock_bits <= lk_val_s;
        if (a4_sync[2] ^ a4_sync[1]) addr4 <= a4_val_s;
      end
    end
  end
endmodule // frc_top
